/* File: design/eeacc_top.sv */
// cpu side access control for a 512 byte data eeprom
// assumes a single-cycle io port, an array that reads combinationally and
// latches address and data on a write start pulse, and a free 1 MHz tick pin
// the 14-bit tick counter limits the write length to 16384 ticks
`timescale 1ns/1ps
`include "eeacc_defs.svh"

module eeacc_top import eeacc_pkg::*; #(
    parameter int unsigned WRITE_TICKS = `EEACC_WRITE_TICKS
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // cpu io port
    input wire eeacc_io_req_t io_req_i,
    output logic [7:0] io_rdata_o,
    input wire logic global_irq_en_i,
    output logic cpu_stall_o,
    output logic ready_irq_o,
    // flash self-programming status
    input wire logic flash_selfprog_enable_i,
    // calibrated oscillator tick, asynchronous
    input wire logic osc_clk_i,
    // eeprom array
    output eeacc_arr_req_t arr_req_o,
    input wire logic [7:0] arr_rdata_i
);

    logic [`EEACC_ADDR_W-1:0] eeprom_address_r;
    logic [7:0] eeprom_data_r;
    logic ready_irq_enable_r;
    logic master_write_enable_r;
    logic write_strobe_r;
    logic [2:0] mwe_cnt_r;
    logic [2:0] stall_cnt_r;
    logic [2:0] stall_cnt_nxt;
    logic [2:0] osc_sync_r;
    logic [13:0] tick_cnt_r;
    logic osc_tick;
    logic ctl_wr;
    logic wr_start;
    logic rd_start;
    logic wr_done;
    logic [7:0] rdata_nxt;

    // true when the io port writes the given register this cycle
    function automatic logic reg_write(input eeacc_io_req_t req, input logic [1:0] sel);
        return req.wr && (req.sel == sel);
    endfunction : reg_write

    // decode of control writes and strobe acceptance
    assign ctl_wr = reg_write(io_req_i, `EEACC_SEL_CONTROL);
    // write needs master enable, idle, and no flash programming
    assign wr_start = ctl_wr && io_req_i.wdata[`EEACC_CTL_WE] && master_write_enable_r
        && !write_strobe_r && !flash_selfprog_enable_i;
    assign rd_start = ctl_wr && io_req_i.wdata[`EEACC_CTL_RE]
        && !write_strobe_r && !wr_start;
    assign osc_tick = osc_sync_r[1] && !osc_sync_r[2];
    assign wr_done = write_strobe_r && osc_tick
        && (tick_cnt_r == 14'(WRITE_TICKS - 1));

    // address register, frozen while a write runs
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            eeprom_address_r <= '0;
        end else if (io_req_i.wr && !write_strobe_r) begin
            if (io_req_i.sel == `EEACC_SEL_ADDR_HI) begin
                eeprom_address_r[8] <= io_req_i.wdata[0];
            end else if (io_req_i.sel == `EEACC_SEL_ADDR_LO) begin
                eeprom_address_r[7:0] <= io_req_i.wdata;
            end
        end
    end

    // data register: software writes, array read captures
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            eeprom_data_r <= `EEACC_ZERO8;
        end else if (rd_start) begin
            eeprom_data_r <= arr_rdata_i;
        end else if (reg_write(io_req_i, `EEACC_SEL_DATA)) begin
            eeprom_data_r <= io_req_i.wdata;
        end
    end

    // ready interrupt enable bit
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ready_irq_enable_r <= 1'b0;
        end else if (ctl_wr) begin
            ready_irq_enable_r <= io_req_i.wdata[`EEACC_CTL_RIE];
        end
    end

    // master write enable with four cycle self-clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            master_write_enable_r <= 1'b0;
            mwe_cnt_r <= '0;
        end else if (ctl_wr && io_req_i.wdata[`EEACC_CTL_MWE]) begin
            master_write_enable_r <= 1'b1;
            mwe_cnt_r <= `EEACC_MWE_CYCLES;
        end else if (mwe_cnt_r != '0) begin
            mwe_cnt_r <= mwe_cnt_r - 3'h1;
            master_write_enable_r <= (mwe_cnt_r != 3'h1);
        end else begin
            master_write_enable_r <= 1'b0;
        end
    end

    // two-flop sync of the oscillator plus edge history
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            osc_sync_r <= '0;
        end else begin
            osc_sync_r <= {osc_sync_r[1:0], osc_clk_i};
        end
    end

    // write busy flag and oscillator tick counter
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            write_strobe_r <= 1'b0;
            tick_cnt_r <= '0;
        end else if (wr_start) begin
            write_strobe_r <= 1'b1;
            tick_cnt_r <= '0;
        end else if (wr_done) begin
            write_strobe_r <= 1'b0;
            tick_cnt_r <= '0;
        end else if (write_strobe_r && osc_tick) begin
            tick_cnt_r <= tick_cnt_r + 14'h1;
        end
    end

    // stall counter next value
    always_comb begin
        stall_cnt_nxt = stall_cnt_r;
        if (wr_start) begin
            stall_cnt_nxt = `EEACC_STALL_WR;
        end else if (rd_start) begin
            stall_cnt_nxt = `EEACC_STALL_RD;
        end else if (stall_cnt_r != '0) begin
            stall_cnt_nxt = stall_cnt_r - 3'h1;
        end
    end

    // stall counter and stall output
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            stall_cnt_r <= '0;
            cpu_stall_o <= 1'b0;
        end else begin
            stall_cnt_r <= stall_cnt_nxt;
            cpu_stall_o <= (stall_cnt_nxt != '0);
        end
    end

    // ready interrupt level while no write runs
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ready_irq_o <= 1'b0;
        end else begin
            ready_irq_o <= ready_irq_enable_r && global_irq_en_i
                && !(write_strobe_r || wr_start) && !wr_done ? 1'b1
                : (ready_irq_enable_r && global_irq_en_i && wr_done);
        end
    end

    // read data mux, reserved bits zero
    always_comb begin
        unique case (io_req_i.sel)
            `EEACC_SEL_ADDR_HI: rdata_nxt = {7'h00, eeprom_address_r[8]};
            `EEACC_SEL_ADDR_LO: rdata_nxt = eeprom_address_r[7:0];
            `EEACC_SEL_DATA: rdata_nxt = eeprom_data_r;
            `EEACC_SEL_CONTROL: rdata_nxt = {4'h0, ready_irq_enable_r,
                master_write_enable_r, write_strobe_r, 1'b0};
        endcase
    end

    // registered read data
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            io_rdata_o <= `EEACC_ZERO8;
        end else if (io_req_i.rd) begin
            io_rdata_o <= rdata_nxt;
        end
    end

    // array request, write start is a one cycle pulse
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            arr_req_o <= '0;
        end else begin
            arr_req_o.addr <= eeprom_address_r;
            arr_req_o.wdata <= eeprom_data_r;
            arr_req_o.we <= wr_start;
        end
    end

    // checks, all on the cpu clock and quiet during reset

    // master enable stays up for the four cycles after it is written
    a_mwe_window: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ctl_wr && io_req_i.wdata[`EEACC_CTL_MWE] |=> master_write_enable_r [*4])
        else $error("master enable dropped inside its window");

    // without a fresh set, master enable is gone on the fifth cycle
    a_mwe_timeout: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ctl_wr && io_req_i.wdata[`EEACC_CTL_MWE]
        ##1 (!(ctl_wr && io_req_i.wdata[`EEACC_CTL_MWE])) [*4] |=> !master_write_enable_r)
        else $error("master enable did not time out after four cycles");

    // a strobe without master enable is ignored
    a_strobe_needs_mwe: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ctl_wr && io_req_i.wdata[`EEACC_CTL_WE] && !master_write_enable_r
        && !write_strobe_r |=> !write_strobe_r)
        else $error("write started without master enable");

    // flash self-programming blocks any write start
    a_flash_block: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        flash_selfprog_enable_i && !write_strobe_r |=> !write_strobe_r)
        else $error("write started during flash programming");

    // write start stalls the cpu for exactly two cycles
    a_write_stall: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_start |=> cpu_stall_o ##1 cpu_stall_o ##1 !cpu_stall_o)
        else $error("write stall is not two cycles");

    // read start stalls the cpu for exactly four cycles
    a_read_stall: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_start |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
        else $error("read stall is not four cycles");

    // read strobe captures the array byte at once
    a_read_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_start |=> eeprom_data_r == $past(arr_rdata_i))
        else $error("read data not captured");

    // address is frozen while a write runs
    a_addr_frozen: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        write_strobe_r |=> $stable(eeprom_address_r))
        else $error("address changed during a write");

    // busy bit holds at least through the start of a write
    a_strobe_held: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(write_strobe_r) |-> write_strobe_r [*8])
        else $error("write strobe dropped early");

    // ready interrupt is a level while idle and enabled
    a_irq_level: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ready_irq_enable_r && global_irq_en_i && !write_strobe_r
        && !wr_start ##1 $stable(ready_irq_enable_r) |-> ready_irq_o)
        else $error("ready interrupt missing while idle");

    // reserved address bits read as zero
    a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        io_req_i.rd && io_req_i.sel == `EEACC_SEL_ADDR_HI |=> io_rdata_o[7:1] == 7'h00)
        else $error("reserved address bits not zero");

    // completion clears busy and never re-pulses the array
    a_single_done: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_done |=> !write_strobe_r && !arr_req_o.we)
        else $error("write completion misbehaved");

    // an accepted strobe raises busy and one array pulse
    a_write_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_start |=> write_strobe_r && arr_req_o.we)
        else $error("accepted write strobe did not start the array");

    // the array never sees a write pulse without an accepted strobe
    a_no_stray_we: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        arr_req_o.we |-> $past(wr_start))
        else $error("array write pulse without a strobe");

    // busy only falls when the tick count completes
    a_strobe_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(write_strobe_r) |-> $past(wr_done))
        else $error("write strobe cleared before the write time");

    // tick counter stays below the write length while busy
    a_tick_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        write_strobe_r |-> tick_cnt_r < 14'(WRITE_TICKS))
        else $error("tick counter ran past the write length");

    // a read strobe during a write leaves the data register alone
    a_read_blocked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ctl_wr && io_req_i.wdata[`EEACC_CTL_RE] && write_strobe_r
        |=> $stable(eeprom_data_r))
        else $error("read happened during a write");

    // no ready interrupt while the write still runs
    a_irq_in_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        write_strobe_r && !wr_done |=> !ready_irq_o)
        else $error("ready interrupt during a write");

    // reserved control bits and the read strobe bit read as zero
    a_ctl_reserved: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        io_req_i.rd && io_req_i.sel == `EEACC_SEL_CONTROL
        |=> io_rdata_o[7:4] == 4'h0 && !io_rdata_o[0])
        else $error("reserved control bits not zero");

    // high address byte write lands in the ninth bit
    a_addr_hi_bit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_write(io_req_i, `EEACC_SEL_ADDR_HI) && !write_strobe_r
        |=> eeprom_address_r[8] == $past(io_req_i.wdata[0]))
        else $error("high address bit not stored");

    // low address byte write lands in the low eight bits
    a_addr_lo_bit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_write(io_req_i, `EEACC_SEL_ADDR_LO) && !write_strobe_r
        |=> eeprom_address_r[7:0] == $past(io_req_i.wdata))
        else $error("low address byte not stored");

    // software data writes land in the data register
    a_data_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reg_write(io_req_i, `EEACC_SEL_DATA) |=> eeprom_data_r == $past(io_req_i.wdata))
        else $error("data register write lost");

    // no stall when nothing started and the counter is empty
    a_stall_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        stall_cnt_r == 3'h0 && !wr_start && !rd_start |=> !cpu_stall_o)
        else $error("stall without an access");

    // the array sees the frozen address throughout a write
    a_arr_addr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        write_strobe_r |=> arr_req_o.addr == $past(eeprom_address_r))
        else $error("array address differs from the register");

    // control writes set the interrupt enable bit
    a_rie_bit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ctl_wr |=> ready_irq_enable_r == $past(io_req_i.wdata[`EEACC_CTL_RIE]))
        else $error("interrupt enable not stored");

    // the global bit masks the ready interrupt
    a_irq_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !global_irq_en_i |=> !ready_irq_o)
        else $error("ready interrupt while globally masked");

    // control reads show the busy bit
    a_ctl_strobe_bit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        io_req_i.rd && io_req_i.sel == `EEACC_SEL_CONTROL |=> io_rdata_o[1] == $past(write_strobe_r))
        else $error("busy bit not visible on read");

endmodule : eeacc_top

/* File: shared/eeacc_defs.svh */
// constants for the eeprom cpu access control block
// assumes a 125 MHz cpu clock and a 1 MHz calibrated oscillator tick input
// Summary of operation
// - address high byte bits 15..9 always read zero
// - nine-bit address picks one byte of 512, numbered 0 to 511
// - address resets to zero; software loads a valid one before any access
// - data register supplies write byte and captures read byte
// - control register bits 7..4 always read zero
// - bit 3 with global enable asserts ready interrupt while write strobe is zero
// - master write enable bit 2 clears itself four cycles after set
// - write strobe bit 1 starts a write only while master enable is set
// - no eeprom write starts while flash self-programming is active
// - write strobe stays set for the whole write, hardware clears it
// - setting write strobe stalls the cpu two cycles
// - read strobe bit 0 reads at once, stalls cpu four cycles
// - during a write, reads and address changes are blocked
// - write lasts 8448 ticks of the 1 MHz oscillator, about 8.5 ms
`ifndef EEACC_DEFS_SVH
`define EEACC_DEFS_SVH

// register selectors on the io port
`define EEACC_SEL_ADDR_HI 2'h0
`define EEACC_SEL_ADDR_LO 2'h1
`define EEACC_SEL_DATA 2'h2
`define EEACC_SEL_CONTROL 2'h3

// control register fields
`define EEACC_CTL_RIE 3
`define EEACC_CTL_MWE 2
`define EEACC_CTL_WE 1
`define EEACC_CTL_RE 0

// address width and timing counts
`define EEACC_ADDR_W 9
`define EEACC_MWE_CYCLES 3'h4
`define EEACC_STALL_WR 3'h2
`define EEACC_STALL_RD 3'h4
`define EEACC_WRITE_TICKS 8448
`define EEACC_WRITE_TIME_US 8500
`define EEACC_ZERO8 8'h00

`endif

/* File: shared/eeacc_pkg.sv */
// types shared by the eeprom cpu access control block
// assumes eeacc_defs.svh is included before use
package eeacc_pkg;
    // one cpu io access to the block
    typedef struct packed {
        logic [1:0] sel;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } eeacc_io_req_t;

    // request to the eeprom array
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic we;
    } eeacc_arr_req_t;
endpackage : eeacc_pkg

/* File: verif/tb_eeacc_top.sv */
// self-checking testbench for the eeprom cpu access control block
// assumes eeacc_top with a short write time, a free 1 MHz oscillator
// and a small behavioural array model driven from the array port
`timescale 1ns/1ps
`include "eeacc_defs.svh"

module tb_eeacc_top import eeacc_pkg::*;;
    localparam int unsigned TICKS = 4;
    // clocks, reset and design ports
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic osc_clk_i = 1'b0;
    eeacc_io_req_t io_req_i = '0;
    logic global_irq_en_i = 1'b0;
    logic flash_selfprog_enable_i = 1'b0;
    logic [7:0] io_rdata_o;
    logic cpu_stall_o;
    logic ready_irq_o;
    eeacc_arr_req_t arr_req_o;
    logic [7:0] arr_rdata_i;
    logic [7:0] mem [512];
    int err_total = 0;
    int comparisons = 0;
    int we_count = 0;
    int n;

    // cpu clock at 125 MHz and oscillator at 1 MHz, each oscillator rise landing on a cpu clock rise
    always #4 clock_i = ~clock_i;
    always #500 osc_clk_i = ~osc_clk_i;

    eeacc_top #(.WRITE_TICKS(TICKS)) i_eeacc_top (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .io_req_i(io_req_i),
        .io_rdata_o(io_rdata_o),
        .global_irq_en_i(global_irq_en_i),
        .cpu_stall_o(cpu_stall_o),
        .ready_irq_o(ready_irq_o),
        .flash_selfprog_enable_i(flash_selfprog_enable_i),
        .osc_clk_i(osc_clk_i),
        .arr_req_o(arr_req_o),
        .arr_rdata_i(arr_rdata_i)
    );

    // array model: combinational read, write latched on the start pulse
    assign arr_rdata_i = mem[arr_req_o.addr];
    always @(posedge clock_i) begin
        if (arr_req_o.we === 1'b1) begin
            mem[arr_req_o.addr] <= arr_req_o.wdata;
            we_count <= we_count + 1;
        end
    end

    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    // one io access, request held for exactly one edge
    task automatic acc(input logic [1:0] s, input logic w, input logic r, input logic [7:0] d);
        @(posedge clock_i);
        io_req_i <= {s, w, r, d};
        @(posedge clock_i);
        io_req_i <= '0;
    endtask : acc

    task automatic rd(input logic [1:0] s, output logic [7:0] v);
        acc(s, 1'b0, 1'b1, 8'h00);
        #1;
        v = io_rdata_o;
    endtask : rd

    // counts cycles of stall, entered right after the launching access
    task automatic stall_len(output int len);
        len = 0;
        #1;
        while (cpu_stall_o === 1'b1 && len < 20) begin
            len++;
            @(posedge clock_i);
            #1;
        end
    endtask : stall_len

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        conclude();
    end

    // main sequence
    initial begin : main
        logic [7:0] v;
        time t0;
        for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5A;
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(`EEACC_SEL_ADDR_HI, v);
        chk("addr_hi reset", 9'h000, {1'b0, v});
        rd(`EEACC_SEL_CONTROL, v);
        chk("control reset", 9'h000, {1'b0, v});
        // load the top address before any access
        acc(`EEACC_SEL_ADDR_HI, 1'b1, 1'b0, 8'hFF);
        acc(`EEACC_SEL_ADDR_LO, 1'b1, 1'b0, 8'hFF);
        rd(`EEACC_SEL_ADDR_HI, v);
        chk("addr_hi reserved", 9'h001, {1'b0, v});
        chk("array address", 9'h1FF, arr_req_o.addr);
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h01);
        stall_len(n);
        chk("read stall", 9'h004, 9'(n));
        rd(`EEACC_SEL_DATA, v);
        chk("read data", 9'h0A5, {1'b0, v});
        // ready interrupt masked, then enabled by the global bit
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h08);
        repeat (2) @(posedge clock_i);
        #1;
        chk("irq masked", 9'h000, {8'h00, ready_irq_o});
        @(posedge clock_i);
        global_irq_en_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        chk("irq enabled", 9'h001, {8'h00, ready_irq_o});
        rd(`EEACC_SEL_CONTROL, v);
        chk("control value", 9'h008, {1'b0, v});
        // strobe without master enable, then under self-programming
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h0A);
        @(posedge clock_i);
        flash_selfprog_enable_i <= 1'b1;
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h0C);
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h0A);
        @(posedge clock_i);
        flash_selfprog_enable_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        chk("no write", 9'h000, 9'(we_count));
        // master enable times out
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h0C);
        rd(`EEACC_SEL_CONTROL, v);
        chk("mwe set", 9'h00C, {1'b0, v});
        repeat (6) @(posedge clock_i);
        rd(`EEACC_SEL_CONTROL, v);
        chk("mwe cleared", 9'h008, {1'b0, v});
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h0A);
        repeat (3) @(posedge clock_i);
        chk("late strobe", 9'h000, 9'(we_count));
        // full write sequence with the ready interrupt enabled
        acc(`EEACC_SEL_DATA, 1'b1, 1'b0, 8'h3C);
        acc(`EEACC_SEL_ADDR_LO, 1'b1, 1'b0, 8'h55);
        acc(`EEACC_SEL_ADDR_HI, 1'b1, 1'b0, 8'h00);
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h0C);
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h0A);
        t0 = $time;
        stall_len(n);
        chk("write stall", 9'h002, 9'(n));
        chk("irq in write", 9'h000, {8'h00, ready_irq_o});
        acc(`EEACC_SEL_ADDR_LO, 1'b1, 1'b0, 8'h10);
        rd(`EEACC_SEL_ADDR_LO, v);
        chk("address locked", 9'h055, {1'b0, v});
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h09);
        stall_len(n);
        chk("blocked stall", 9'h000, 9'(n));
        rd(`EEACC_SEL_DATA, v);
        chk("read blocked", 9'h03C, {1'b0, v});
        rd(`EEACC_SEL_CONTROL, v);
        chk("strobe held", 9'h00A, {1'b0, v});
        // poll until hardware clears the strobe
        n = 0;
        while (v[1] === 1'b1 && n < 600) begin
            rd(`EEACC_SEL_CONTROL, v);
            n++;
        end
        chk("write time", 9'h001, 9'(($time - t0) >= (TICKS - 1) * 1000
            && ($time - t0) <= (TICKS + 1) * 1000 + 200));
        chk("strobe cleared", 9'h008, {1'b0, v});
        chk("one write", 9'h001, 9'(we_count));
        repeat (2) @(posedge clock_i);
        #1;
        chk("irq after write", 9'h001, {8'h00, ready_irq_o});
        // read back the byte just written
        acc(`EEACC_SEL_CONTROL, 1'b1, 1'b0, 8'h01);
        rd(`EEACC_SEL_DATA, v);
        chk("written byte", 9'h03C, {1'b0, v});
        conclude();
    end
endmodule : tb_eeacc_top
